/* File: src/touch_setup_regs.vh */
/*
 * command codes, setting limits, storage map and timing constants of the
 * touch report and key setup block.
 * assumes: included by bare name from the design files of this block only.
 */
`ifndef TOUCH_SETUP_REGS_VH
`define TOUCH_SETUP_REGS_VH

// ************************************************************
// command codes
// ************************************************************
`define CMD_NEG_THR       8'h01
`define CMD_POS_THR       8'h02
`define CMD_NEG_HYST      8'h03
`define CMD_POS_HYST      8'h04
`define CMD_DWELL         8'h05
`define CMD_BURST_LEN     8'h06
`define CMD_BURST_SPACE   8'h07
`define CMD_TOUCH_REPORT  8'h4b
`define REPLY_NONE        8'h00

// ************************************************************
// scope codes
// ************************************************************
`define SCOPE_KEY         2'h0
`define SCOPE_ROW         2'h1
`define SCOPE_COL         2'h2
`define SCOPE_ALL         2'h3

// ************************************************************
// setting limits and fixed values
// ************************************************************
`define THR_MIN           8'h04
`define THR_MAX           8'h40
`define BLEN_MAX          8'h40
`define HYST_MAX          8'h03
`define SPACE_MAX         8'h05
`define DWELL_FIXED       8'h01
`define HYST_DEFAULT      2'h1
`define SPACE_DEFAULT     3'h3

// ************************************************************
// storage map: {table select, key}
// ************************************************************
`define SEL_NEG_THR       2'h0
`define SEL_POS_THR       2'h1
`define SEL_BURST_LEN     2'h2
`define SEL_GLOBAL        2'h3
`define GADDR_NEG_HYST    6'h00
`define GADDR_POS_HYST    6'h01
`define GADDR_SPACE       6'h02
`define GADDR_LAST        6'h03

// ************************************************************
// report and timing
// ************************************************************
`define REPORT_LAST_IDX   4'h8
`define KEYS_LAST         6'h3f
`define LINE_LAST         6'h07
`define CLK_MHZ           20
`define NV_WRITE_US       10000
`define SPACE0_US         16'd250
`define SPACE1_US         16'd300
`define SPACE2_US         16'd400
`define SPACE3_US         16'd500
`define SPACE4_US         16'd1000
`define SPACE5_US         16'd2000

`endif

/* File: src/setup_store.v */
/*
 * setup storage: one write port and two read ports with registered data.
 * stands in for the nonvolatile array, so it has no reset; contents start
 * blank (zero) once and are never cleared by the block reset.
 * assumes: single clock, writer avoids reading a word in its write cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module setup_store #(
    parameter AW = 8,
    parameter DW = 8
) (
    // clock
    input  wire          clk_i,
    // write port
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [DW-1:0] wdata_i,
    // read ports
    input  wire [AW-1:0] ra_addr_i,
    output reg  [DW-1:0] ra_data_o,
    input  wire [AW-1:0] rb_addr_i,
    output reg  [DW-1:0] rb_data_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    // blank part: model of an erased array at power-up
    initial
    begin
        for (i = 0; i < (1<<AW); i = i + 1)
            mem[i] = {DW{1'b0}};
    end

    always @(posedge clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
        ra_data_o <= mem[ra_addr_i];
        rb_data_o <= mem[rb_addr_i];
    end

endmodule // setup_store

`default_nettype wire

/* File: src/touch_report_and_key_setup.v */
/*
 * command interpreter for the touch report and the first setup commands of a
 * 64-key matrix sensor, with a serial slave port and the burst slot scanner.
 * assumes: serial pins are asynchronous (mode 0, msb first, sck well below
 * clk_i/4); touch_i and delta_i come from acquisition logic on clk_i.
 */
// What this block does
// - touch report returns one byte for key, row, column scope, eight for all
// - single-key scope reports the key state in bit 0 only
// - row reply carries Y7..Y0 of that row, column reply X7..X0
// - all-keys byte n carries Y line n-1, bit k is X line k, byte 1 first
// - a touched key reads one, an untouched key zero
// - setups live in nonvolatile storage; changes never stop key sensing
// - setup writes take much longer than other commands; host waits
// - a setup write acts right after the command echo
// - negative threshold 0x01 stores for scoped keys, range 0x04..0x40
// - key detects when delta reaches negative threshold
// - positive threshold 0x02 stores scoped value from the sixteen-value set
// - settings outside the valid list round down before storing; thresholds below 0x04 rise to 0x04
// - negative hysteresis 0x03 all keys, 0..3 map to 50,25,12.5,0 percent
// - hysteresis level sits between threshold and reference, near threshold
// - global settings move a single byte for put and get
// - positive hysteresis 0x04 same as negative, for positive detections
// - dwell 0x05 accepted, stays one cycle, read gives 0x01
// - burst length 0x06 stored per scoped key, range 0x00..0x40
// - burst length zero disables the key, flags error, keeps its slot
// - burst spacing 0x07 applies to all keys, range 0x00..0x05
// - spacing 0..5 give 250,300,400,500,1000,2000 us; larger clamps to 2000
// - one full scan is spacing times sixty-four
`timescale 1ns/10ps
`default_nettype none
`include "touch_setup_regs.vh"

module touch_report_and_key_setup #(
    parameter NV_WRITE_CYCLES = `NV_WRITE_US * `CLK_MHZ
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // serial port pins
    input  wire        sck_i,
    input  wire        ss_n_i,
    input  wire        mosi_i,
    output reg         miso_o,
    // control
    input  wire        get_mode_i,
    input  wire [1:0]  scope_i,
    input  wire [5:0]  scope_idx_i,
    output reg         busy_o,
    // acquisition side
    input  wire [63:0] touch_i,
    input  wire [7:0]  delta_i,
    output reg         burst_start_o,
    output reg  [5:0]  burst_key_o,
    output reg  [7:0]  burst_len_o,
    output reg         key_error_o,
    output reg         detect_o,
    output reg         scan_done_o,
    output reg  [1:0]  neg_hyst_o,
    output reg  [1:0]  pos_hyst_o
);

    localparam ST_LOAD = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_ARG  = 3'h2;
    localparam ST_GET1 = 3'h3;
    localparam ST_GET2 = 3'h4;
    localparam ST_REP  = 3'h5;
    localparam ST_WR   = 3'h6;

    // ************************************************************
    // functions
    // ************************************************************
    function [5:0] scope_key;
        input [1:0] sc;
        input [5:0] idx;
        input [5:0] n;
        begin
            case (sc)
                `SCOPE_ROW: scope_key = {n[2:0], idx[2:0]};
                `SCOPE_COL: scope_key = {idx[2:0], n[2:0]};
                `SCOPE_ALL: scope_key = n;
                default:    scope_key = idx;
            endcase
        end
    endfunction

    function [7:0] report_byte;
        input [1:0]  sc;
        input [5:0]  idx;
        input [2:0]  n;
        input [63:0] t;
        integer      k;
        begin
            report_byte = 8'h00;
            for (k = 0; k < 8; k = k + 1)
            begin
                case (sc)
                    `SCOPE_KEY: report_byte[k] = (k == 0) ? t[idx] : 1'b0;
                    `SCOPE_ROW: report_byte[k] = t[{k[2:0], idx[2:0]}];
                    `SCOPE_COL: report_byte[k] = t[{idx[2:0], k[2:0]}];
                    default:    report_byte[k] = t[{n, k[2:0]}];
                endcase
            end
        end
    endfunction

    function [7:0] clamp;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
        end
    endfunction

    // round down onto the positive threshold set; below the set gives its floor
    function [7:0] pos_round;
        input [7:0] v;
        begin
            if      (v >= 8'd64) pos_round = 8'd64;
            else if (v >= 8'd55) pos_round = 8'd55;
            else if (v >= 8'd45) pos_round = 8'd45;
            else if (v >= 8'd35) pos_round = 8'd35;
            else if (v >= 8'd30) pos_round = 8'd30;
            else if (v >= 8'd25) pos_round = 8'd25;
            else if (v >= 8'd20) pos_round = 8'd20;
            else if (v >= 8'd17) pos_round = 8'd17;
            else if (v >= 8'd15) pos_round = 8'd15;
            else if (v >= 8'd12) pos_round = 8'd12;
            else if (v >= 8'd10) pos_round = 8'd10;
            else if (v >= 8'd8)  pos_round = 8'd8;
            else if (v >= 8'd4)  pos_round = v;
            else                 pos_round = `THR_MIN;
        end
    endfunction

    function [15:0] space_cycles;
        input [2:0] s;
        reg   [31:0] c;
        begin
            case (s)
                3'h0:    c = `SPACE0_US * `CLK_MHZ;
                3'h1:    c = `SPACE1_US * `CLK_MHZ;
                3'h2:    c = `SPACE2_US * `CLK_MHZ;
                3'h3:    c = `SPACE3_US * `CLK_MHZ;
                3'h4:    c = `SPACE4_US * `CLK_MHZ;
                default: c = `SPACE5_US * `CLK_MHZ;
            endcase
            space_cycles = c[15:0];
        end
    endfunction

    // ************************************************************
    // serial pin synchronisers and byte framing
    // ************************************************************
    reg [2:0] sck_q;
    reg [1:0] ss_q;
    reg [1:0] mosi_q;
    reg       ss_prev_q;
    reg [2:0] bit_q;
    reg [6:0] rx_sh_q;
    reg [7:0] tx_sh_q;
    reg [7:0] tx_next_q;
    wire      sck_rise = sck_q[1] & ~sck_q[2];
    wire      sck_fall = ~sck_q[1] & sck_q[2];
    wire      sel      = ~ss_q[1];
    wire      rx_stb   = sel & sck_rise & (bit_q == 3'h7);
    wire [7:0] rx_byte = {rx_sh_q, mosi_q[1]};

    always @(posedge clk_i)
    begin
        sck_q  <= {sck_q[1:0], sck_i};
        ss_q   <= {ss_q[0], ss_n_i};
        mosi_q <= {mosi_q[0], mosi_i};
        if (!rstn_i)
        begin
            ss_prev_q <= 1'b1;
            bit_q     <= 3'h0;
            rx_sh_q   <= 7'h00;
            tx_sh_q   <= 8'h00;
            miso_o    <= 1'b0;
        end
        else
        begin
            ss_prev_q <= ss_q[1];
            if (!sel)
                bit_q <= 3'h0;
            else if (sck_rise)
            begin
                bit_q   <= bit_q + 3'h1;
                rx_sh_q <= rx_byte[6:0];
            end
            // a new byte is loaded at select and after every eighth bit
            if (sel && (ss_prev_q || (sck_fall && bit_q == 3'h0)))
                tx_sh_q <= tx_next_q;
            else if (sel && sck_fall)
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            miso_o <= tx_sh_q[7];
        end
    end

    // ************************************************************
    // command interpreter
    // ************************************************************
    reg [2:0]  state_q;
    reg [7:0]  cmd_q;
    reg [7:0]  arg_q;
    reg [1:0]  scope_q;
    reg [5:0]  idx_q;
    reg [3:0]  rep_q;
    reg [5:0]  cnt_q;
    reg        wr_done_q;
    reg [31:0] nv_q;
    reg [2:0]  space_q;
    reg [5:0]  slot_q;
    reg [1:0]  ph_q;
    reg [15:0] spc_q;
    wire [7:0] ra_data;
    wire [7:0] rb_data;

    wire       per_key = (cmd_q == `CMD_NEG_THR) || (cmd_q == `CMD_POS_THR) || (cmd_q == `CMD_BURST_LEN);
    wire [1:0] tsel    = (cmd_q == `CMD_NEG_THR) ? `SEL_NEG_THR :
                         (cmd_q == `CMD_POS_THR) ? `SEL_POS_THR :
                         (cmd_q == `CMD_BURST_LEN) ? `SEL_BURST_LEN : `SEL_GLOBAL;
    wire [5:0] gaddr   = (cmd_q == `CMD_NEG_HYST) ? `GADDR_NEG_HYST :
                         (cmd_q == `CMD_POS_HYST) ? `GADDR_POS_HYST : `GADDR_SPACE;
    wire [5:0] last_n  = (scope_q == `SCOPE_ALL) ? `KEYS_LAST :
                         (scope_q == `SCOPE_KEY) ? 6'h00 : `LINE_LAST;
    wire [7:0] ra_addr = (state_q == ST_LOAD) ? {`SEL_GLOBAL, cnt_q} :
                         per_key ? {tsel, scope_key(scope_q, idx_q, 6'h00)} : {`SEL_GLOBAL, gaddr};
    wire       we      = (state_q == ST_WR) && !wr_done_q && (cmd_q != `CMD_DWELL);
    wire [7:0] waddr   = per_key ? {tsel, scope_key(scope_q, idx_q, cnt_q)} : {`SEL_GLOBAL, gaddr};
    wire       setup   = (rx_byte >= `CMD_NEG_THR) && (rx_byte <= `CMD_BURST_SPACE);
    wire       nv_end  = (nv_q >= NV_WRITE_CYCLES - 1);
    wire [7:0] load_v  = clamp(ra_data, 8'h00, (cnt_q == `GADDR_LAST) ? `SPACE_MAX : `HYST_MAX);

    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= ST_LOAD;
            cmd_q      <= `REPLY_NONE;
            arg_q      <= 8'h00;
            scope_q    <= `SCOPE_ALL;
            idx_q      <= 6'h00;
            rep_q      <= 4'h0;
            cnt_q      <= 6'h00;
            wr_done_q  <= 1'b0;
            nv_q       <= 32'h0;
            tx_next_q  <= `REPLY_NONE;
            busy_o     <= 1'b1;
            neg_hyst_o <= `HYST_DEFAULT;
            pos_hyst_o <= `HYST_DEFAULT;
            space_q    <= `SPACE_DEFAULT;
        end
        else
        begin
            case (state_q)
                ST_LOAD:
                begin
                    // globals come back from storage after every reset
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == 6'h01)
                        neg_hyst_o <= load_v[1:0];
                    if (cnt_q == 6'h02)
                        pos_hyst_o <= load_v[1:0];
                    if (cnt_q == `GADDR_LAST)
                    begin
                        space_q <= load_v[2:0];
                        state_q <= ST_IDLE;
                        busy_o  <= 1'b0;
                    end
                end
                ST_IDLE:
                begin
                    if (rx_stb)
                    begin
                        cmd_q   <= rx_byte;
                        scope_q <= scope_i;
                        idx_q   <= scope_idx_i;
                        if (rx_byte == `CMD_TOUCH_REPORT)
                        begin
                            tx_next_q <= report_byte(scope_i, scope_idx_i, 3'h0, touch_i);
                            rep_q     <= (scope_i == `SCOPE_ALL) ? 4'h1 : `REPORT_LAST_IDX;
                            state_q   <= ST_REP;
                        end
                        else if (setup && get_mode_i)
                            state_q <= ST_GET1;
                        else if (setup)
                        begin
                            tx_next_q <= rx_byte;
                            state_q   <= ST_ARG;
                        end
                        else
                            tx_next_q <= `REPLY_NONE;
                    end
                end
                ST_ARG:
                begin
                    if (rx_stb)
                    begin
                        case (cmd_q)
                            `CMD_NEG_THR:     arg_q <= clamp(rx_byte, `THR_MIN, `THR_MAX);
                            `CMD_POS_THR:     arg_q <= pos_round(rx_byte);
                            `CMD_BURST_LEN:   arg_q <= clamp(rx_byte, 8'h00, `BLEN_MAX);
                            `CMD_BURST_SPACE: arg_q <= clamp(rx_byte, 8'h00, `SPACE_MAX);
                            `CMD_DWELL:       arg_q <= `DWELL_FIXED;
                            default:          arg_q <= clamp(rx_byte, 8'h00, `HYST_MAX);
                        endcase
                        tx_next_q <= `REPLY_NONE;
                        cnt_q     <= 6'h00;
                        wr_done_q <= 1'b0;
                        nv_q      <= 32'h0;
                        busy_o    <= 1'b1;
                        state_q   <= ST_WR;
                    end
                end
                ST_GET1:
                    state_q <= ST_GET2;
                ST_GET2:
                begin
                    case (cmd_q)
                        `CMD_DWELL:       tx_next_q <= `DWELL_FIXED;
                        `CMD_NEG_HYST:    tx_next_q <= {6'h00, neg_hyst_o};
                        `CMD_POS_HYST:    tx_next_q <= {6'h00, pos_hyst_o};
                        `CMD_BURST_SPACE: tx_next_q <= {5'h00, space_q};
                        default:          tx_next_q <= ra_data;
                    endcase
                    rep_q   <= `REPORT_LAST_IDX;
                    state_q <= ST_REP;
                end
                ST_REP:
                begin
                    // the byte that clocks out the last reply is a dummy, not a command
                    if (rx_stb && rep_q == `REPORT_LAST_IDX)
                    begin
                        tx_next_q <= `REPLY_NONE;
                        state_q   <= ST_IDLE;
                    end
                    else if (rx_stb)
                    begin
                        tx_next_q <= report_byte(scope_q, idx_q, rep_q[2:0], touch_i);
                        rep_q     <= rep_q + 4'h1;
                    end
                end
                ST_WR:
                begin
                    // values act from the first cycle; the scanner never pauses
                    nv_q <= nv_q + 32'h1;
                    if (!wr_done_q)
                    begin
                        cnt_q <= cnt_q + 6'h01;
                        if (!per_key || cnt_q == last_n)
                            wr_done_q <= 1'b1;
                        if (cmd_q == `CMD_NEG_HYST)
                            neg_hyst_o <= arg_q[1:0];
                        if (cmd_q == `CMD_POS_HYST)
                            pos_hyst_o <= arg_q[1:0];
                        if (cmd_q == `CMD_BURST_SPACE)
                            space_q <= arg_q[2:0];
                    end
                    // bytes arriving now are dropped until storage is done
                    if (wr_done_q && nv_end)
                    begin
                        busy_o  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    setup_store #(
        .AW (8),
        .DW (8)
    ) u_store (
        .clk_i     (clk_i),
        .we_i      (we),
        .waddr_i   (waddr),
        .wdata_i   (arg_q),
        .ra_addr_i (ra_addr),
        .ra_data_o (ra_data),
        .rb_addr_i ({(ph_q == 2'h2) ? `SEL_NEG_THR : `SEL_BURST_LEN, slot_q}),
        .rb_data_o (rb_data)
    );

    // ************************************************************
    // burst slot scanner and detection
    // ************************************************************
    wire [7:0] rel_lvl = (neg_hyst_o == 2'h3) ? rb_data : rb_data - (rb_data >> ({1'b0, neg_hyst_o} + 3'h1));

    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            spc_q         <= 16'h0000;
            slot_q        <= `KEYS_LAST;
            ph_q          <= 2'h0;
            burst_start_o <= 1'b0;
            burst_key_o   <= 6'h00;
            burst_len_o   <= 8'h00;
            key_error_o   <= 1'b0;
            detect_o      <= 1'b0;
            scan_done_o   <= 1'b0;
        end
        else
        begin
            burst_start_o <= 1'b0;
            scan_done_o   <= 1'b0;
            detect_o      <= 1'b0;
            // a slot passes for every key, enabled or not, so scan time is fixed
            if (spc_q >= space_cycles(space_q) - 16'h1)
            begin
                spc_q       <= 16'h0000;
                slot_q      <= slot_q + 6'h01;
                scan_done_o <= (slot_q == `KEYS_LAST);
                ph_q        <= 2'h1;
            end
            else
                spc_q <= spc_q + 16'h1;
            if (ph_q == 2'h1)
                ph_q <= 2'h2;
            if (ph_q == 2'h2)
            begin
                burst_start_o <= 1'b1;
                burst_key_o   <= slot_q;
                burst_len_o   <= rb_data;
                key_error_o   <= (rb_data == 8'h00);
                ph_q          <= 2'h3;
            end
            if (ph_q == 2'h3)
            begin
                // release level lies between threshold and reference
                detect_o <= !key_error_o &&
                            (touch_i[burst_key_o] ? (delta_i >= rel_lvl) : (delta_i >= rb_data));
                ph_q     <= 2'h0;
            end
        end
    end

endmodule // touch_report_and_key_setup

`default_nettype wire

/* File: test/touch_setup_chk_assertions.sv */
/* port checker for the touch report and key setup block
   assumes: bound into the block, one clock, reset active low */
`timescale 1ns/10ps
`default_nettype none
module touch_setup_chk (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rstn_i,
    // watched outputs
    input wire logic       busy_o,
    input wire logic       burst_start_o,
    input wire logic [5:0] burst_key_o,
    input wire logic [7:0] burst_len_o,
    input wire logic       key_error_o,
    input wire logic       detect_o,
    input wire logic       scan_done_o,
    input wire logic [1:0] neg_hyst_o,
    input wire logic [1:0] pos_hyst_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [15:0] gap_q;
    logic        seen_q;
    logic [5:0]  last_q;
    always @(posedge clk_i)
    begin
        gap_q  <= burst_start_o ? 16'h0001 : gap_q + 16'h0001;
        seen_q <= rstn_i & (seen_q | burst_start_o);
        last_q <= burst_start_o ? burst_key_o : last_q;
    end
    sequence load_s;
        busy_o [*4] ##1 !busy_o;
    endsequence
    reset_load_a: assert property ($rose(rstn_i) |-> load_s)
        else $error("busy after reset wrong");
    write_busy_a: assert property ($rose(busy_o) |-> busy_o [*8] ##[1:300] !busy_o)
        else $error("storage write busy wrong");
    detect_follow_a: assert property (detect_o |-> $past(burst_start_o))
        else $error("detect without slot start");
    key_error_a: assert property (burst_start_o |-> key_error_o == (burst_len_o == 8'h00))
        else $error("key error flag wrong");
    blen_range_a: assert property (burst_start_o |-> burst_len_o <= 8'h40)
        else $error("burst length above limit");
    key_order_a: assert property (burst_start_o && seen_q |-> burst_key_o == last_q + 6'h01)
        else $error("slot key order wrong");
    slot_gap_a: assert property (burst_start_o && seen_q |-> gap_q >= 16'h1388 && gap_q <= 16'h9c40)
        else $error("slot spacing out of range");
    hyst_hold_a: assert property (!busy_o && !$past(busy_o) |-> $stable({neg_hyst_o, pos_hyst_o}))
        else $error("hysteresis moved while idle");
    scan_wrap_a: assert property (burst_start_o && burst_key_o == 6'h00 |-> $past(scan_done_o, 2))
        else $error("no scan wrap");
endmodule // touch_setup_chk
`default_nettype wire

/* File: test/touch_host_model.sv */
/* host side of the serial port: mode 0, msb first, select held low
   assumes: called by the bench one byte at a time */
`timescale 1ns/10ps
`default_nettype none
module touch_host_model (
    // serial pins
    output var logic       sck_o,
    output var logic       ss_n_o,
    output var logic       mosi_o,
    input wire logic       miso_i,
    // last byte seen and byte count
    output var logic [7:0] rx_o,
    output var int         rx_cnt_o
);
    initial
    begin
        {sck_o, ss_n_o, mosi_o, rx_o, rx_cnt_o} = {3'b010, 8'h00, 32'h0};
    end
    // long low phase so the reply bit has settled before the rise
    task automatic xfer(input logic [7:0] tx, input int gap);
        #(gap + 1) ss_n_o = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_o = tx[i];
            #250 sck_o = 1'b1;
            rx_o[i] = miso_i;
            #150 sck_o = 1'b0;
        end
        mosi_o = ~mosi_o;
        rx_cnt_o++;
    endtask
endmodule // touch_host_model
`default_nettype wire

/* File: test/touch_report_and_key_setup_tb_top.sv */
/* bench for the touch report and key setup block
   assumes: host model on the serial pins, storage starts blank */
`timescale 1ns/10ps
`default_nettype none
module touch_report_and_key_setup_tb_top;
    logic clk_i = 1'b0, rstn_i = 1'b0, get_mode_i = 1'b0;
    logic [1:0] scope_i = 2'h3;
    logic [5:0] scope_idx_i = 6'h00, k;
    logic [63:0] touch_i = 64'h0;
    logic [7:0] delta_i = 8'h00, rx, e;
    logic [15:0] m, exp_q[$];
    logic [7:0] tab [7][3] = '{'{8'h01, 8'h50, 8'h40}, '{8'h02, 8'h09, 8'h08}, '{8'h03, 8'h02, 8'h02},
        '{8'h04, 8'h07, 8'h03}, '{8'h05, 8'h09, 8'h01}, '{8'h06, 8'h4f, 8'h40}, '{8'h07, 8'h09, 8'h05}};
    wire logic sck, ss_n, mosi, miso, busy;
    wire logic [1:0] nh, ph;
    int fail_count = 0, checked = 0, seed = 32'hd2d8d7cd, rx_cnt;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) delta_i <= 8'($random(seed));
    touch_host_model u_host (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso), .rx_o(rx), .rx_cnt_o(rx_cnt));
    touch_report_and_key_setup #(.NV_WRITE_CYCLES(200)) u_touch_report_and_key_setup (.clk_i(clk_i),
        .rstn_i(rstn_i), .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .get_mode_i(get_mode_i),
        .scope_i(scope_i), .scope_idx_i(scope_idx_i), .busy_o(busy), .touch_i(touch_i), .delta_i(delta_i),
        .burst_start_o(), .burst_key_o(), .burst_len_o(), .key_error_o(), .detect_o(), .scan_done_o(),
        .neg_hyst_o(nh), .pos_hyst_o(ph));
    task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
        checked++;
        if (got !== ex)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // each byte leaves a note; a zero mask means the reply is not checked
    task automatic send(input logic [7:0] tx, input logic [7:0] mask, input logic [7:0] ex);
        exp_q.push_back({mask, ex});
        u_host.xfer(tx, $random(seed) & 32'h1ff);
    endtask
    always @(rx_cnt)
    begin
        m = exp_q.size() > 0 ? exp_q.pop_front() : 16'h0000;
        if (m[15:8] != 8'h00)
            chk("reply", m[7:0], rx & m[15:8]);
    end
    task automatic mode(input logic g, input logic [1:0] s, input logic [5:0] i);
        @(posedge clk_i);
        {get_mode_i, scope_i, scope_idx_i} <= {g, s, i};
        @(posedge clk_i);
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 400)
        begin
            fail_count++;
            close_out();
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        wait_busy(1'b0);
        touch_i <= {$random(seed), $random(seed)};
        mode(1'b0, 2'h3, 6'h00);
        send(8'h4b, 8'h00, 8'h00);
        for (int n = 0; n < 8; n++) send(8'h00, 8'hff, touch_i[8*n +: 8]);
        for (int s = 0; s < 3; s++)
        begin
            k = 6'($random(seed));
            mode(1'b0, 2'(s), k);
            for (int y = 0; y < 8; y++) e[y] = touch_i[8*y + k[2:0]];
            e = (s == 0) ? {7'h00, touch_i[k]} : (s == 2) ? touch_i[8*k[2:0] +: 8] : e;
            send(8'h4b, 8'h00, 8'h00);
            send(8'h00, (s == 0) ? 8'h7f : 8'hff, e);
        end
        for (int i = 0; i < 7; i++)
        begin
            if (i == 6) repeat (11000) @(posedge clk_i);
            mode(1'b0, (i == 0) ? 2'h0 : 2'h3, k);
            send(tab[i][0], 8'h00, 8'h00);
            send(tab[i][1], 8'hff, tab[i][0]);
            wait_busy(1'b1);
            if (i == 5) send(8'h4b, 8'h00, 8'h00);
            if (i == 5) send(8'h55, 8'hff, 8'h00);
            wait_busy(1'b0);
            mode(1'b1, 2'h0, k);
            send(tab[i][0], 8'h00, 8'h00);
            send(8'h00, 8'hff, tab[i][2]);
        end
        @(posedge clk_i);
        chk("neg hyst", 8'h02, {6'h00, nh});
        chk("pos hyst", 8'h03, {6'h00, ph});
        close_out();
    end
endmodule // touch_report_and_key_setup_tb_top
bind touch_report_and_key_setup touch_setup_chk u_touch_setup_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .busy_o(busy_o), .burst_start_o(burst_start_o), .burst_key_o(burst_key_o), .burst_len_o(burst_len_o),
    .key_error_o(key_error_o), .detect_o(detect_o), .scan_done_o(scan_done_o), .neg_hyst_o(neg_hyst_o),
    .pos_hyst_o(pos_hyst_o));
`default_nettype wire
